/* File: src/mram_spi_top.sv */
// Serial memory pin interface: command decode, shift logic, tri-state.
// Assumes sck_in is the host serial clock and may stop at any time;
// clk_in is the free running system clock used for pin status.
`timescale 1ns/1ns

// Contract
// - Select high: inputs ignored, output released, standby shown.
// - Output driven only while read data is being returned.
// - Hold low releases the output at once, even mid-read.
// - Output bits change only on serial clock falling edges.
// - Write-protect low blocks status writes when the lock bit is set.
// - Serial input sampled only on serial clock rising edges.
// - Output tri-states so a joined data wire can be host driven.
// - Works with the clock idling low or idling high.
// - Fully static logic; clock may stop anywhere in a transfer.
// - Hold low suspends the operation without aborting it.
// - Hold low masks select and serial clock edges from the frame; a rising edge on a write byte's last bit still writes the array.
// - Array of 131072 locations of eight bits each.
// - Writes complete at bus speed with no busy period.
// - Clock idle level at select fall picks the clock mode.
// - One command per select, first byte is the command code.
module mram_spi_top
   import mram_spi_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   output logic so_out,
   output logic so_oe_n_out,
   output logic standby_out
);

   // System clock side: pin filters and standby flag
   logic cs_s1_q;
   logic cs_s2_q;
   logic cs_s3_q;
   logic standby_q;
   logic wp_s1_q;
   logic wp_s2_q;
   logic wp_s3_q;
   logic wp_q;
   logic rst_req_q;

   // Serial clock side
   logic wp_l1_q;
   logic wp_l2_q;
   logic rst_l1_q;
   logic rst_l2_q;
   phase_type phase_q;
   phase_type phase_d;
   logic [2:0] bit_q;
   logic [2:0] bit_d;
   logic [6:0] shift_q;
   logic [6:0] shift_d;
   logic [16:0] addr_q;
   logic [16:0] addr_d;
   logic [1:0] abyte_q;
   logic [1:0] abyte_d;
   logic is_read_q;
   logic is_read_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic started_q;
   logic mode3_q;
   logic so_q;
   logic so_oe_n_q;
   logic wr_en;

   mram_mem_if mem ();

   // Decode wires
   logic frame_rst;
   logic oe_off;
   logic [7:0] in_byte;
   logic byte_end;
   logic wel;
   logic status_lock;
   logic status_writable;
   logic drive_phase;
   logic [1:0] bp_sel;
   logic lead_fall;

   function automatic logic block_protected(input logic [1:0] bp,
                                            input logic [16:0] a);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         BP_NONE: hit = 1'b0;
         BP_QUARTER: hit = (a[16:15] == TOP_QUARTER);
         BP_HALF: hit = a[16];
         BP_ALL: hit = 1'b1;
      endcase
      return hit;
   endfunction : block_protected

   // Select only resets the frame while hold is high, so a select
   // edge under hold is masked; both pins are host driven and clean
   assign frame_rst = cs_n_in & hold_n_in;
   assign oe_off = cs_n_in | ~hold_n_in;
   assign in_byte = {shift_q, si_in};
   assign byte_end = (bit_q == BIT_LAST);
   assign wel = status_q[ST_WEL_BIT];
   assign status_lock = status_q[ST_LOCK_BIT];
   assign status_writable = wel & ~(status_lock & ~wp_l2_q);
   assign bp_sel = {status_q[ST_BP1_BIT], status_q[ST_BP0_BIT]};
   assign drive_phase = (phase_q == PH_RD) || (phase_q == PH_SR_RD);
   // Mode 3 opens with one falling edge that carries no data bit
   assign lead_fall = ~started_q & ~mode3_q;

   // Read address runs one edge ahead so the next byte is ready in time
   assign mem.wr_en = wr_en;
   assign mem.wr_addr = addr_q;
   assign mem.wr_data = in_byte;
   assign mem.rd_addr = addr_d;

   mram_array u_array (
      .sck_in (sck_in),
      .mem (mem)
   );

   // Pin filters on the system clock; a change counts once two agree
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         wp_s1_q <= 1'b1;
         wp_s2_q <= 1'b1;
         wp_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= cs_n_in;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         wp_s1_q <= wp_n_in;
         wp_s2_q <= wp_s1_q;
         wp_s3_q <= wp_s2_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         standby_q <= 1'b1;
         wp_q <= 1'b1;
         rst_req_q <= 1'b1;
      end else begin
         rst_req_q <= 1'b0;
         if (cs_s2_q == cs_s3_q) begin
            standby_q <= cs_s3_q;
         end
         if (wp_s2_q == wp_s3_q) begin
            wp_q <= wp_s3_q;
         end
      end
   end

   // Level crossings into the serial domain. The status clear needs a
   // few serial clock edges during reset since that clock may be idle.
   // Both are slow levels, so two flops suffice on this side
   always_ff @(posedge sck_in) begin
      wp_l1_q <= wp_q;
      wp_l2_q <= wp_l1_q;
      rst_l1_q <= rst_req_q;
      rst_l2_q <= rst_l1_q;
   end

   // Next state of the frame, one bit per rising edge
   always_comb begin
      phase_d = phase_q;
      bit_d = bit_q + 3'h1;
      shift_d = in_byte[6:0];
      addr_d = addr_q;
      abyte_d = abyte_q;
      is_read_d = is_read_q;
      tx_d = tx_q;
      status_d = status_q;
      wr_en = 1'b0;
      if (phase_q == PH_ADDR) begin
         addr_d = {addr_q[15:0], si_in};
      end
      if (byte_end) begin
         unique case (phase_q)
            PH_CMD: begin
               phase_d = PH_DONE;
               unique case (in_byte)
                  OP_WRITE_ENABLE: status_d[ST_WEL_BIT] = 1'b1;
                  OP_WRITE_DISABLE: status_d[ST_WEL_BIT] = 1'b0;
                  OP_READ_STATUS: begin
                     phase_d = PH_SR_RD;
                     tx_d = status_q;
                  end
                  OP_WRITE_STATUS: phase_d = PH_SR_WR;
                  OP_READ: begin
                     phase_d = PH_ADDR;
                     is_read_d = 1'b1;
                  end
                  OP_WRITE: begin
                     phase_d = PH_ADDR;
                     is_read_d = 1'b0;
                  end
                  default: phase_d = PH_DONE;
               endcase
            end
            PH_ADDR: begin
               abyte_d = abyte_q + 2'h1;
               if (abyte_q == ADDR_BYTE_LAST) begin
                  phase_d = is_read_q ? PH_RD : PH_WR;
                  tx_d = mem.rd_data;
               end
            end
            PH_RD: begin
               addr_d = addr_q + ADDR_STEP;
               tx_d = mem.rd_data;
            end
            PH_WR: begin
               wr_en = wel & ~block_protected(bp_sel, addr_q);
               addr_d = addr_q + ADDR_STEP;
            end
            PH_SR_RD: tx_d = status_q;
            PH_SR_WR: begin
               if (status_writable) begin
                  status_d = (in_byte & ST_WRITE_MASK) |
                             (status_q & ~ST_WRITE_MASK);
               end
               phase_d = PH_DONE;
            end
            PH_DONE: phase_d = PH_DONE;
            default: phase_d = PH_DONE;
         endcase
      end
   end

   // Frame state; cleared by the select itself since the clock may stop.
   // Under hold nothing moves, so the frame resumes at the same bit.
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         phase_q <= PH_CMD;
         bit_q <= BIT_FIRST;
         shift_q <= 7'h00;
         addr_q <= 17'h00000;
         abyte_q <= ADDR_BYTE_FIRST;
         is_read_q <= 1'b0;
         tx_q <= 8'h00;
         started_q <= 1'b0;
      end else if (hold_n_in) begin
         phase_q <= phase_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         addr_q <= addr_d;
         abyte_q <= abyte_d;
         is_read_q <= is_read_d;
         tx_q <= tx_d;
         started_q <= 1'b1;
      end
   end

   // Status keeps its value across frames; static, no refresh needed
   always_ff @(posedge sck_in) begin
      if (rst_l2_q) begin
         status_q <= ST_RESET;
      end else if (hold_n_in && !cs_n_in) begin
         status_q <= status_d;
      end
   end

   // A falling edge before any rising edge means the clock idled high
   always_ff @(negedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         mode3_q <= 1'b0;
         so_q <= 1'b0;
      end else if (hold_n_in) begin
         if (lead_fall) begin
            mode3_q <= 1'b1;
         end else begin
            so_q <= tx_q[BIT_LAST - bit_q];
         end
      end
   end

   // Enable is forced off asynchronously so hold or select act at once
   always_ff @(negedge sck_in or posedge oe_off) begin
      if (oe_off) begin
         so_oe_n_q <= 1'b1;
      end else begin
         so_oe_n_q <= ~(started_q & drive_phase);
      end
   end

   assign so_out = so_q;
   assign so_oe_n_out = so_oe_n_q;
   assign standby_out = standby_q;

endmodule : mram_spi_top

/* File: src/mram_spi_pkg.sv */
// Constants shared by the serial memory pin interface and its array.
// Assumes a byte-wide array addressed by a 17-bit word address.
package mram_spi_pkg;

   // Array organisation
   localparam int unsigned MEM_DEPTH = 131072;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 8;

   // Serial framing
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_BYTE_FIRST = 2'h0;
   localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
   localparam logic [16:0] ADDR_STEP = 17'h00001;

   // System clock
   localparam int unsigned CLK_PERIOD_NS = 100;

   // Command codes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;

   // Status register fields
   localparam int unsigned ST_LOCK_BIT = 7;
   localparam int unsigned ST_BP1_BIT = 3;
   localparam int unsigned ST_BP0_BIT = 2;
   localparam int unsigned ST_WEL_BIT = 1;
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [7:0] ST_WRITE_MASK = 8'hFD;

   // Block protection encodings
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [1:0] TOP_QUARTER = 2'h3;

   typedef enum logic [2:0] {
      PH_CMD,
      PH_ADDR,
      PH_RD,
      PH_WR,
      PH_SR_RD,
      PH_SR_WR,
      PH_DONE
   } phase_type;

endpackage : mram_spi_pkg

/* File: src/mram_mem_if.sv */
// Port bundle between the serial front end and the storage array.
// Assumes both ends sit on the serial clock.
`timescale 1ns/1ns
interface mram_mem_if;
   logic wr_en;
   logic [16:0] wr_addr;
   logic [7:0] wr_data;
   logic [16:0] rd_addr;
   logic [7:0] rd_data;

   modport ctrl (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input rd_data
   );

   modport array (
      input wr_en,
      input wr_addr,
      input wr_data,
      input rd_addr,
      output rd_data
   );
endinterface : mram_mem_if

/* File: src/mram_array.sv */
// Byte-wide storage array, one write per serial clock rising edge.
// Assumes the front end presents write data in the same edge it completes.
`timescale 1ns/1ns
module mram_array
   import mram_spi_pkg::*;
(
   input wire logic sck_in,
   mram_mem_if.array mem
);

   logic [7:0] store_q [0:MEM_DEPTH-1];

   // No wait state: each byte lands on the edge that completes it
   always_ff @(posedge sck_in) begin
      if (mem.wr_en) begin
         store_q[mem.wr_addr] <= mem.wr_data;
      end
   end

   // Read is combinational so the next byte is ready before its first bit
   assign mem.rd_data = store_q[mem.rd_addr];

endmodule : mram_array

/* File: testbench/serial_mram_spi_chk.sv */
// Checker for the serial memory pin interface, bound to its top module.
// Assumes one host per frame and hold edges inside the clock high phase.
`timescale 1ns/1ns
module serial_mram_spi_chk (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   input wire logic so_out,
   input wire logic so_oe_n_out,
   input wire logic standby_out
);
   logic [5:0] cnt_q;
   logic [7:0] op_q;
   logic so_rise_q;
   // Counts rising edges of the frame, frozen while hold is low
   always_ff @(posedge sck_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         cnt_q <= 6'h00;
         op_q <= 8'h00;
      end else if (hold_n_in) begin
         if (cnt_q < 6'h08) op_q <= {op_q[6:0], si_in};
         if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
      end
   end
   always_ff @(posedge sck_in) begin
      so_rise_q <= so_out;
   end
   wire rd_go = (op_q == 8'h03 && cnt_q >= 6'h20) ||
      (op_q == 8'h05 && cnt_q >= 6'h08);
   sequence sel_low;
      !cs_n_in [*6];
   endsequence
   sequence sel_high;
      cs_n_in [*6];
   endsequence
   a_desel_release: assert property (@(posedge clk_in) disable iff (!resetn_in) cs_n_in |-> so_oe_n_out) else $error("output driven while deselected");
   a_hold_release: assert property (@(posedge clk_in) disable iff (!resetn_in) !hold_n_in |-> so_oe_n_out) else $error("output driven during hold");
   a_standby_on: assert property (@(posedge clk_in) disable iff (!resetn_in) sel_high |-> standby_out) else $error("standby missing");
   a_standby_off: assert property (@(posedge clk_in) disable iff (!resetn_in) sel_low |-> !standby_out) else $error("standby while selected");
   a_drive_only_read: assert property (@(posedge sck_in) disable iff (!resetn_in) !so_oe_n_out |-> rd_go) else $error("output driven outside a read");
   a_drive_on_read: assert property (@(posedge sck_in) disable iff (!resetn_in) (hold_n_in && !cs_n_in && rd_go) |-> !so_oe_n_out) else $error("read data not driven");
   a_so_fall_only: assert property (@(negedge sck_in) disable iff (!resetn_in) !so_oe_n_out |-> so_out == so_rise_q) else $error("output moved on a rising edge");
   a_hold_freeze: assert property (@(negedge sck_in) disable iff (!resetn_in) (!hold_n_in && !cs_n_in) |=> $stable(so_out)) else $error("output moved during hold");
endmodule : serial_mram_spi_chk
bind mram_spi_top serial_mram_spi_chk chk (.clk_in(clk_in),
   .resetn_in(resetn_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
   .hold_n_in(hold_n_in), .wp_n_in(wp_n_in), .so_out(so_out),
   .so_oe_n_out(so_oe_n_out), .standby_out(standby_out));

/* File: testbench/spi_host_model.sv */
// Behavioural SPI host that frames whole bytes on a 12 ns serial clock.
// Assumes a single memory on the bus; clock stands at idle outside frames.
`timescale 1ns/1ns
module spi_host_model (
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   output logic hold_n_out,
   input wire logic so_in,
   input wire logic so_oe_n_in
);
   logic idle_q = 1'b0;
   logic hold_oe = 1'b1;
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
      hold_n_out = 1'b1;
   end
   task automatic kick();
      repeat (4) begin
         #6 sck_out = ~idle_q;
         #6 sck_out = idle_q;
      end
   endtask : kick
   task automatic start(input logic m3);
      idle_q = m3;
      sck_out = m3;
      #6 cs_n_out = 1'b0;
      #6;
   endtask : start
   // Released line reads back inverted, so stale data never matches
   task automatic byte_x(input logic [7:0] tx, input int pause,
                         output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_out = 1'b0;
         si_out = tx[i];
         #6 sck_out = 1'b1;
         rx[i] = so_oe_n_in ? ~so_in : so_in;
         if (pause == i) begin
            // Hold moves clear of the rising edge so that edge still counts
            #3 hold_n_out = 1'b0;
            #100 sck_out = 1'b0;
            #6 sck_out = 1'b1;
            #150 hold_oe &= so_oe_n_in;
            hold_n_out = 1'b1;
         end
         #6;
      end
   endtask : byte_x
   // Clock returns to idle after the last byte; select rises only on a byte boundary
   task automatic stop();
      #6 sck_out = idle_q;
      #6 cs_n_out = 1'b1;
      #12;
   endtask : stop
endmodule : spi_host_model

/* File: testbench/test_serial_mram_spi_pin_interface.sv */
// Self-checking bench: host model on the pins, checker bound to the top.
// Assumes the package constants for command codes and clock period.
`timescale 1ns/1ns
module test_serial_mram_spi_pin_interface;
   import mram_spi_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic wp_n_in = 1'b1;
   wire sck, cs_n, si, hold_n, so, so_oe_n, standby;
   int n_fail = 0;
   int comparisons = 0;
   logic [7:0] tx_b [8];
   logic [7:0] rx_b [8];
   always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
   mram_spi_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .sck_in(sck),
      .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
      .so_out(so), .so_oe_n_out(so_oe_n), .standby_out(standby));
   spi_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
      .hold_n_out(hold_n), .so_in(so), .so_oe_n_in(so_oe_n));
   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk
   task automatic run(input logic m3, input int n, input int pause);
      host.start(m3);
      for (int i = 0; i < n; i++) host.byte_x(tx_b[i], pause - 8 * i, rx_b[i]);
      host.stop();
   endtask : run
   task automatic wren();
      tx_b[0] = OP_WRITE_ENABLE;
      run(1'b0, 1, -1);
   endtask : wren
   task automatic t_write_wrap();
      wren();
      tx_b = '{OP_WRITE, 8'h01, 8'hFF, 8'hFF, 8'hA5, 8'h3C, 8'h00, 8'h00};
      run(1'b0, 6, -1);
      tx_b[0] = OP_READ;
      run(1'b1, 6, -1);
      chk("read top", 8'hA5, rx_b[4]);
      chk("read wrap", 8'h3C, rx_b[5]);
      tx_b[1] = 8'hFE;
      tx_b[2] = 8'h00;
      tx_b[3] = 8'h00;
      run(1'b0, 5, -1);
      chk("read low", 8'h3C, rx_b[4]);
   endtask : t_write_wrap
   task automatic t_hold();
      tx_b = '{OP_READ, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      run(1'b0, 6, 35);
      chk("held read", 8'hA5, rx_b[4]);
      chk("after hold", 8'h3C, rx_b[5]);
      chk("hold release", 8'h01, {7'h00, host.hold_oe});
   endtask : t_hold
   // Write enable, status write, then read the status back
   task automatic sr_try(input logic [7:0] val, input logic [7:0] exp);
      wren();
      tx_b[0] = OP_WRITE_STATUS;
      tx_b[1] = val;
      run(1'b0, 2, -1);
      tx_b[0] = OP_READ_STATUS;
      run(1'b1, 3, -1);
      chk("status", exp, rx_b[1]);
      chk("status again", exp, rx_b[2]);
   endtask : sr_try
   task automatic t_protect();
      sr_try(8'h80, 8'h82);
      @(posedge clk_in) wp_n_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      sr_try(8'h0C, 8'h82);
      @(posedge clk_in) wp_n_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      sr_try(8'h00, 8'h02);
   endtask : t_protect
   // Write disable clears the latch, so a later array write is refused
   task automatic t_wrdi();
      tx_b[0] = OP_WRITE_DISABLE;
      run(1'b0, 1, -1);
      tx_b = '{OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00};
      run(1'b1, 5, -1);
      tx_b[0] = OP_READ_STATUS;
      run(1'b0, 2, -1);
      chk("status cleared", 8'h00, rx_b[1]);
      tx_b[0] = OP_READ;
      run(1'b0, 5, -1);
      chk("refused write", 8'h3C, rx_b[4]);
   endtask : t_wrdi
   task automatic t_desel();
      repeat (6) @(posedge clk_in);
      #10;
      chk("standby", 8'h01, {7'h00, standby});
      chk("released", 8'h01, {7'h00, so_oe_n});
   endtask : t_desel
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      // Status clear needs serial clock edges while reset is low
      @(posedge clk_in);
      host.kick();
      @(posedge clk_in) resetn_in <= 1'b1;
      @(posedge clk_in);
      t_write_wrap();
      t_hold();
      t_protect();
      t_wrdi();
      t_desel();
      results();
   end
   initial begin
      #300000;
      n_fail++;
      results();
   end
endmodule : test_serial_mram_spi_pin_interface
